// [src/prom_prog_map.svh]
`ifndef PROM_PROG_MAP_SVH
`define PROM_PROG_MAP_SVH
// Clock and timing, figures as printed
`define CLK_PERIOD_NS 25
`define SUPPLY_RAMP_NS 10000
`define PROGRAM_DELAY_NS 10000
`define PROGRAM_PULSE_NS 100000
`define TOTAL_PULSE_NS 1000000
`define CYCLES_MIN(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RAMP_CYCLES `CYCLES_MIN(`SUPPLY_RAMP_NS)
`define DELAY_CYCLES `CYCLES_MIN(`PROGRAM_DELAY_NS)
`define PULSE_CYCLES (`PROGRAM_PULSE_NS / `CLK_PERIOD_NS)
`define TOTAL_CYCLES (`TOTAL_PULSE_NS / `CLK_PERIOD_NS)
// Memory shape
`define WORD_COUNT 1024
`define ADDR_BITS 10
`define DATA_BITS 8
`define ERASED_WORD 8'hFF
`endif

// [src/prom_prog_pkg.sv]
package prom_prog_pkg;
  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_DESEL   = 8'h02,
    ST_RAMP    = 8'h04,
    ST_DELAY   = 8'h08,
    ST_PULSE   = 8'h10,
    ST_LOWER   = 8'h20,
    ST_VERIFY  = 8'h40,
    ST_DONE    = 8'h80
  } prog_state_e;
endpackage

// [src/wait_timer_if.sv]
`timescale 1ns/1ps
interface wait_timer_if;
  logic start;
  logic [31:0] load;
  logic expired;
  modport owner (output start, output load, input expired);
  modport timer (input start, input load, output expired);
endinterface

// [src/wait_timer.sv]
`timescale 1ns/1ps
module wait_timer (
  input wire logic clk_sys,
  input wire logic rst,
  wait_timer_if.timer t
);
  logic [31:0] count;
  // Expired is a one-cycle pulse when the loaded count runs out
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count <= 32'h0000_0000;
      t.expired <= 1'b0;
    end else if (t.start) begin
      count <= t.load;
      t.expired <= 1'b0;
    end else if (count == 32'h0000_0001) begin
      count <= 32'h0000_0000;
      t.expired <= 1'b1;
    end else begin
      t.expired <= 1'b0;
      if (count != 32'h0000_0000) begin
        count <= count - 32'h0000_0001;
      end
    end
  end
endmodule

// [src/prom_programmer.sv]
`timescale 1ns/1ps
`include "prom_prog_map.svh"
// How it works
// [R01] The part arrives with every bit at 1, so only 0 bits of the target word need a pulse.
// [R02] The part is 1024 words of 8 bits; address and data widths follow that.
// [R03] The word address is driven on all address lines, always actively, before anything else.
// [R04] All four active-low selects are driven high before the supply is raised.
// [R05] Data pins not being pulsed are released so their programming circuits stay idle.
// [R06] The supply request goes to programming level and the ramp time is waited out.
// [R07] After the program delay one enable pulse of the pulse width goes to the selected output.
// [R08] Remaining bits of the word follow one at a time, each at least a program delay apart.
// [R09] A program delay after the last pulse the supply request returns to normal level.
// [R10] Verify drives all selects low and compares the read word with the target.
// [R11] A blown fuse is expected to read low and an intact one high during verify.
// [R12] Failing bits are retried from deselect until they have had the total pulse time.
// [R13] Every 0 bit of the word goes through address, program and verify.
// [R14] Pulse time is summed per bit and a reject reports address, expected and read data.
module prom_programmer
  import prom_prog_pkg::*;
#(
  parameter int ADDR_W = `ADDR_BITS,
  parameter int DATA_W = `DATA_BITS,
  parameter int RAMP_CYC = `RAMP_CYCLES,
  parameter int DELAY_CYC = `DELAY_CYCLES,
  parameter int PULSE_CYC = `PULSE_CYCLES,
  parameter int TOTAL_CYC = `TOTAL_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Command from the user side
  input wire logic start,
  input wire logic [ADDR_W-1:0] word_addr,
  input wire logic [DATA_W-1:0] word_data,
  output logic busy,
  output logic done,
  output logic reject,
  output logic [ADDR_W-1:0] reject_addr,
  output logic [DATA_W-1:0] reject_expected,
  output logic [DATA_W-1:0] reject_read,
  // Device pins
  output logic [ADDR_W-1:0] addr_line,
  output logic select_n_1,
  output logic select_n_2,
  output logic select_n_3,
  output logic select_n_4,
  output logic program_supply_level,
  output logic [DATA_W-1:0] output_program_level,
  output logic [DATA_W-1:0] data_out_oe,
  input wire logic [DATA_W-1:0] data_out_in
);
  // ----------------------------------------
  // Timer and state
  // ----------------------------------------
  wait_timer_if tmr ();
  wait_timer u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .t(tmr.timer)
  );
  prog_state_e state;
  logic [DATA_W-1:0] target;
  logic [DATA_W-1:0] pending;
  logic [$clog2(DATA_W)-1:0] bit_sel;
  logic [31:0] spent [DATA_W];
  logic pulsed_any;
  logic settle;
  logic [DATA_W-1:0] need;
  logic [DATA_W-1:0] pick;
  logic [$clog2(DATA_W)-1:0] next_bit;
  logic have_bit;
  logic [DATA_W-1:0] exhausted;
  logic [DATA_W-1:0] failing;

  // ----------------------------------------
  // Bit selection
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      exhausted[i] = spent[i] >= 32'(TOTAL_CYC);
    end
    need = pending & ~exhausted;
    pick = need & (~need + {{(DATA_W-1){1'b0}}, 1'b1});
    next_bit = '0;
    have_bit = |need;
    for (int i = 0; i < DATA_W; i++) begin
      if (pick[i]) begin
        next_bit = i[$clog2(DATA_W)-1:0];
      end
    end
  end
  // [R11] Bits meant to be 0 that still read 1
  assign failing = ~target & data_out_in;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    tmr.start = 1'b0;
    tmr.load = 32'h0000_0000;
    case (state)
      ST_IDLE: begin
        tmr.start = start;
        tmr.load = 32'h0000_0001;
      end
      ST_DESEL: begin
        tmr.start = tmr.expired;
        tmr.load = 32'(RAMP_CYC);
      end
      ST_RAMP: begin
        tmr.start = tmr.expired;
        tmr.load = 32'(DELAY_CYC);
      end
      ST_DELAY: begin
        tmr.start = tmr.expired;
        // One short of the width: the output stays up for the cycle in which expiry is seen
        tmr.load = have_bit ? 32'(PULSE_CYC - 1) : 32'(RAMP_CYC);
      end
      ST_PULSE: begin
        tmr.start = tmr.expired;
        tmr.load = 32'(DELAY_CYC);
      end
      ST_LOWER: begin
        tmr.start = tmr.expired;
        tmr.load = 32'h0000_0001;
      end
      ST_VERIFY: begin
        // Deselect on a retry waits on this kick
        tmr.start = settle; // [R12]
        tmr.load = 32'h0000_0001;
      end
      default: begin
        tmr.start = 1'b0;
        tmr.load = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_IDLE;
      settle <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_DESEL; // [R03] [R13]
          end
        end
        ST_DESEL: if (tmr.expired) begin
          state <= ST_RAMP; // [R04]
        end
        ST_RAMP: if (tmr.expired) begin
          state <= ST_DELAY; // [R06]
        end
        ST_DELAY: if (tmr.expired) begin
          state <= have_bit ? ST_PULSE : ST_LOWER; // [R07] [R08] [R09]
        end
        ST_PULSE: if (tmr.expired) begin
          state <= ST_DELAY;
        end
        ST_LOWER: if (tmr.expired) begin
          state <= ST_VERIFY;
          settle <= 1'b0;
        end
        ST_VERIFY: begin
          // One settle cycle for the read path before sampling
          settle <= 1'b1;
          if (settle) begin
            settle <= 1'b0;
            state <= (|(failing & ~exhausted)) ? ST_DESEL : ST_DONE; // [R12]
          end
        end
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Per-bit bookkeeping
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      target <= `ERASED_WORD;
      pending <= '0;
      bit_sel <= '0;
      pulsed_any <= 1'b0;
      for (int i = 0; i < DATA_W; i++) begin
        spent[i] <= 32'h0000_0000;
      end
    end else if (state == ST_IDLE && start) begin
      target <= word_data;
      pending <= ~word_data; // [R01]
      pulsed_any <= 1'b0;
      for (int i = 0; i < DATA_W; i++) begin
        spent[i] <= 32'h0000_0000;
      end
    end else if (state == ST_DELAY && tmr.expired && have_bit) begin
      bit_sel <= next_bit;
      pending[next_bit] <= 1'b0;
      pulsed_any <= 1'b1;
    end else if (state == ST_PULSE) begin
      spent[bit_sel] <= spent[bit_sel] + 32'h0000_0001; // [R14]
    end else if (state == ST_VERIFY && settle) begin
      pending <= failing; // [R12]
    end
  end

  // ----------------------------------------
  // Pins and status, all registered
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr_line <= '0;
      select_n_1 <= 1'b1;
      select_n_2 <= 1'b1;
      select_n_3 <= 1'b1;
      select_n_4 <= 1'b1;
      program_supply_level <= 1'b0;
      output_program_level <= '0;
      data_out_oe <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      reject <= 1'b0;
      reject_addr <= '0;
      reject_expected <= '0;
      reject_read <= '0;
    end else begin
      done <= 1'b0;
      reject <= 1'b0;
      if (state == ST_IDLE && start) begin
        addr_line <= word_addr; // [R03]
        busy <= 1'b1;
      end
      // [R04] [R10] Selects high except during verify and the one cycle after it
      select_n_1 <= ~(state == ST_LOWER && tmr.expired || state == ST_VERIFY);
      select_n_2 <= ~(state == ST_LOWER && tmr.expired || state == ST_VERIFY);
      select_n_3 <= ~(state == ST_LOWER && tmr.expired || state == ST_VERIFY);
      select_n_4 <= ~(state == ST_LOWER && tmr.expired || state == ST_VERIFY);
      // [R06] [R09] Supply high from ramp until the trailing delay ends
      if (state == ST_DESEL && tmr.expired) begin
        program_supply_level <= 1'b1;
      end else if (state == ST_DELAY && tmr.expired && !have_bit) begin
        program_supply_level <= 1'b0;
      end
      // [R05] [R07] Only the selected output is driven, only during its pulse
      if (state == ST_DELAY && tmr.expired && have_bit) begin
        output_program_level <= pick;
        data_out_oe <= pick;
      end else if (state == ST_PULSE && tmr.expired) begin
        output_program_level <= '0;
        data_out_oe <= '0;
      end
      // Done leaves together with any reject so both read as one answer
      if (state == ST_VERIFY && settle && !(|(failing & ~exhausted))) begin
        done <= 1'b1; // [R13]
      end
      if (state == ST_DONE) begin
        busy <= 1'b0;
      end
      if (state == ST_VERIFY && settle && |failing && !(|(failing & ~exhausted))) begin
        reject <= 1'b1; // [R14]
        reject_addr <= addr_line;
        reject_expected <= target;
        reject_read <= data_out_in;
      end
    end
  end
endmodule

// [verif/prom_programmer_props.sv]
`timescale 1ns/1ps
// ----
// Pin sequencing checks
// ----
module prom_programmer_props #(
  parameter int DELAY_CYC = 4,
  parameter int PULSE_CYC = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic busy,
  input wire logic done,
  input wire logic reject,
  input wire logic [9:0] addr_line,
  input wire logic select_n_1,
  input wire logic select_n_2,
  input wire logic select_n_3,
  input wire logic select_n_4,
  input wire logic program_supply_level,
  input wire logic [7:0] output_program_level,
  input wire logic [7:0] data_out_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic on;
  logic desel;
  int plen;
  int gap;
  assign on = |output_program_level;
  assign desel = select_n_1 & select_n_2 & select_n_3 & select_n_4;
  // Gap restarts at supply rise and at each pulse end
  always_ff @(posedge clk_sys) begin
    plen <= (rst || !on) ? 0 : plen + 1;
    gap <= (rst || $rose(program_supply_level) || $fell(on)) ? 1 : gap + 1;
  end
  sequence s_on;
    $rose(on);
  endsequence
  sequence s_off;
    $fell(on);
  endsequence
  a_desel_at_ramp: assert property ($rose(program_supply_level) |-> desel && $past(desel))
    else $error("supply raised while selected");
  a_pulse_at_level: assert property (on |-> program_supply_level && desel)
    else $error("pulse without programming supply");
  a_single_pulse: assert property ($onehot0(output_program_level))
    else $error("two outputs pulsed at once");
  a_idle_released: assert property ((data_out_oe & ~output_program_level) == 8'h00)
    else $error("unpulsed output driven");
  a_pulse_delay: assert property (s_on |-> gap >= DELAY_CYC)
    else $error("pulse too soon");
  a_pulse_width: assert property (s_off |-> plen == PULSE_CYC)
    else $error("pulse width wrong");
  a_lower_delay: assert property ($fell(program_supply_level) |-> gap >= DELAY_CYC && !on)
    else $error("supply lowered too soon");
  a_verify_low: assert property (!select_n_1 |-> !program_supply_level && !on)
    else $error("verify at programming level");
  a_addr_held: assert property (busy && $past(busy) |-> $stable(addr_line))
    else $error("address moved while busy");
  a_reject_done: assert property (reject |-> done)
    else $error("reject without done");
  a_start_taken: assert property (start && !busy |=> busy)
    else $error("start not taken");
endmodule
bind prom_programmer prom_programmer_props #(.DELAY_CYC(DELAY_CYC), .PULSE_CYC(PULSE_CYC)) u_props (
  .clk_sys(clk_sys), .rst(rst), .start(start), .busy(busy), .done(done), .reject(reject),
  .addr_line(addr_line), .select_n_1(select_n_1), .select_n_2(select_n_2), .select_n_3(select_n_3),
  .select_n_4(select_n_4), .program_supply_level(program_supply_level),
  .output_program_level(output_program_level), .data_out_oe(data_out_oe));

// [verif/fuse_prom_model.sv]
`timescale 1ns/1ps
// ----
// Fuse memory on the far side
// ----
module fuse_prom_model (
  // Pins from the programmer
  input wire logic [9:0] addr_line,
  input wire logic select_n_1,
  input wire logic select_n_2,
  input wire logic select_n_3,
  input wire logic select_n_4,
  input wire logic program_supply_level,
  input wire logic [7:0] output_program_level,
  // Read back and fault mask
  output logic [7:0] data_out,
  input wire logic [7:0] stuck
);
  logic [7:0] mem [1024];
  logic [7:0] prev = 8'h00;
  logic desel;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  assign desel = select_n_1 & select_n_2 & select_n_3 & select_n_4;
  // Fuse opens at pulse end; stuck bits model fuses that never open
  always @(output_program_level) begin
    for (int i = 0; i < 8; i++) begin
      if (prev[i] && !output_program_level[i] && program_supply_level && desel && !stuck[i])
        mem[addr_line][i] = 1'b0;
    end
    prev = output_program_level;
  end
  // Deselected pins show the inverse so stale data is never mistaken for a read
  assign data_out = (!(select_n_1 | select_n_2 | select_n_3 | select_n_4) && !program_supply_level) ?
                    mem[addr_line] : ~mem[addr_line];
endmodule

// [verif/fuse_prom_program_verify_tb_top.sv]
`timescale 1ns/1ps
// ----
// Programmer bench
// ----
module fuse_prom_program_verify_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic [9:0] w_addr = 10'h000;
  logic [7:0] w_data = 8'h00;
  logic [7:0] stuck = 8'h00;
  logic busy, done, reject, sn1, sn2, sn3, sn4, sup;
  logic [9:0] r_addr, addr;
  logic [7:0] r_exp, r_read, opl, oe, rd, prev;
  int n_mismatch = 0;
  int cmp_count = 0;
  int np [8];
  prom_programmer #(.RAMP_CYC(4), .DELAY_CYC(4), .PULSE_CYC(8), .TOTAL_CYC(16)) dut (
    .clk_sys(clk_sys), .rst(rst), .start(start), .word_addr(w_addr), .word_data(w_data),
    .busy(busy), .done(done), .reject(reject), .reject_addr(r_addr), .reject_expected(r_exp),
    .reject_read(r_read), .addr_line(addr), .select_n_1(sn1), .select_n_2(sn2), .select_n_3(sn3),
    .select_n_4(sn4), .program_supply_level(sup), .output_program_level(opl), .data_out_oe(oe),
    .data_out_in(rd));
  fuse_prom_model u_prom (.addr_line(addr), .select_n_1(sn1), .select_n_2(sn2), .select_n_3(sn3),
    .select_n_4(sn4), .program_supply_level(sup), .output_program_level(opl), .data_out(rd), .stuck(stuck));
  always #12.5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    for (int i = 0; i < 8; i++) np[i] += int'(opl[i] & ~prev[i]);
    prev = opl;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic go(input logic [9:0] a, input logic [7:0] d);
    foreach (np[i]) np[i] = 0;
    w_addr <= a;
    w_data <= d;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
  endtask
  task automatic finish_word();
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (done !== 1'b1 && n < 3000);
    check("done", 16'(done), 16'h0001);
  endtask
  task automatic t_word(input logic [9:0] a, input logic [7:0] d);
    go(a, d);
    finish_word();
    check("reject", 16'(reject), 16'h0000);
    check("stored", 16'(u_prom.mem[a]), 16'(d));
    for (int i = 0; i < 8; i++) check("pulses", 16'(np[i]), 16'(!d[i]));
    @(posedge clk_sys);
    $display("word %h done", a);
  endtask
  task automatic t_reject();
    stuck <= 8'h80;
    go(10'h2AA, 8'h7E);
    finish_word();
    check("reject", 16'(reject), 16'h0001);
    check("rej addr", 16'(r_addr), 16'h02AA);
    check("rej exp", 16'(r_exp), 16'h007E);
    check("rej read", 16'(r_read), 16'h00FE);
    check("retries", 16'(np[7]), 16'h0002);
    @(posedge clk_sys);
    stuck <= 8'h00;
    $display("reject done");
  endtask
  task automatic t_busy();
    go(10'h0F0, 8'hFE);
    repeat (5) @(posedge clk_sys);
    go(10'h0F1, 8'h00);
    @(negedge clk_sys);
    check("addr", 16'(addr), 16'h00F0);
    finish_word();
    check("ignored", 16'(u_prom.mem[10'h0F1]), 16'h00FF);
    check("stored", 16'(u_prom.mem[10'h0F0]), 16'h00FE);
    @(posedge clk_sys);
    $display("busy start done");
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check("idle pins", 16'({sn1, sn2, sn3, sn4, sup, busy, oe}), 16'h3C00);
    @(posedge clk_sys);
    t_word(10'h000, 8'h5A);
    t_word(10'h3FF, 8'h00);
    t_word(10'h155, 8'hFF);
    t_reject();
    t_busy();
    complete_run();
  end
endmodule
